// ### ictb_top.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ictb_params.svh"

// Notes on behaviour
// - Timer idle-stop bit set halts counting in Idle; clear keeps it running, except a paired lower half halts when the upper half's bit is set.
// - Gate enable ignored with external clock; with internal clock it gates counting.
// - Prescale codes 11,10,01,00 divide timer input by 256, 64, 8, 1.
// - Clock source one counts external pin rising edges, zero counts pclk.
// - Each qualifying event that finds buffer space latches the full 16-bit selected timer count.
// - Simple modes capture on falling, rising, or every edge.
// - Prescaled modes capture every fourth or every sixteenth rising edge.
// - Each channel selects either of two timers, each clocked internally or externally.
// - Capture pin event raises a wake request in Sleep or Idle.
// - Each channel buffers captures in a four-entry FIFO.
// - Capture interrupt raised after one, two, three or four entries filled.
// - Only channels one and two raise DMA requests; DMA use needs field 00.
// - Up to eight independent channels, each usable as an interrupt source.
// - Captures-per-interrupt 00,01,10,11 interrupt every first to fourth capture.
// - Read-only overflow flag sets when a capture arrives with buffer full.
module ictb_top
    import ictb_pkg::*;
#(
    parameter int NUM_CH = `ICTB_NUM_CH,
    parameter int DEPTH  = `ICTB_FIFO_DEPTH
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              idle_mode,
    input  wire logic              sleep_mode,
    input  wire logic [1:0]        external_timer_clock_pin,
    input  wire logic [NUM_CH-1:0] capture_input_pin,
    output logic [NUM_CH-1:0]      capture_irq,
    output logic [1:0]             dma_req,
    output logic                   wake_req
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (NUM_CH < 1 || NUM_CH > `ICTB_NUM_CH || DEPTH < 4 ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_params
        $error("ictb_top: unsupported NUM_CH or DEPTH");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        ictb_word_t                          lo_ctrl;
        ictb_word_t                          hi_ctrl;
        ictb_word_t                          lo_cnt;
        ictb_word_t                          hi_cnt;
        ictb_ps_t                            lo_ps;
        ictb_ps_t                            hi_ps;
        logic [1:0]                          ext_prev;
        logic [NUM_CH-1:0][7:0]              cc;
        logic [NUM_CH-1:0][DEPTH-1:0][15:0]  fifo;
        logic [NUM_CH-1:0][PW-1:0]           wp;
        logic [NUM_CH-1:0][PW-1:0]           rp;
        logic [NUM_CH-1:0][PW:0]             fill;
        logic [NUM_CH-1:0]                   pin_prev;
        logic [NUM_CH-1:0][3:0]              edge_cnt;
        logic [NUM_CH-1:0][1:0]              int_cnt;
        logic [NUM_CH-1:0]                   irq;
        logic [1:0]                          dma;
        logic                                wake;
        logic [31:0]                         rdata;
        logic                                slverr;
    } ictb_st_t;

    ictb_st_t st_r;
    ictb_st_t st_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Returns {tick, next prescale count}
    function automatic logic [8:0] ictb_prescale(input logic [1:0] sel,
                                                 input ictb_ps_t   ps,
                                                 input logic       src);
        ictb_ps_t last;
        case (sel)
            2'b11:   last = `ICTB_PS256_LAST;
            2'b10:   last = `ICTB_PS64_LAST;
            2'b01:   last = `ICTB_PS8_LAST;
            default: last = `ICTB_PS1_LAST;
        endcase
        if (!src) begin
            return {1'b0, ps};
        end else if (ps >= last) begin
            return {1'b1, 8'h00};
        end
        return {1'b0, 8'(ps + 8'h01)};
    endfunction

    function automatic logic [11:0] ictb_ch_addr(input int c, input logic [11:0] off);
        return 12'(`ICTB_CH_BASE + 12'(c) * `ICTB_CH_STRIDE + off);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic       wr_acc;
    logic       rd_acc;
    logic       setup;
    logic [1:0] ext_rise;
    logic       pair;
    logic       lo_src;
    logic       hi_src;
    logic       lo_run;
    logic       hi_run;
    logic       lo_tick;
    logic       hi_tick;
    logic       hi_inc;
    logic [8:0] ps_res;

    always_comb begin
        logic       rise;
        logic       fall;
        logic       ev;
        logic       push;
        logic       pop;
        logic       full;
        logic [3:0] elast;
        ictb_word_t tval;
        st_nxt  = st_r;
        rise    = 1'b0;
        fall    = 1'b0;
        ev      = 1'b0;
        push    = 1'b0;
        pop     = 1'b0;
        full    = 1'b0;
        elast   = 4'h0;
        tval    = 16'h0000;
        wr_acc  = psel && penable && pwrite;
        rd_acc  = psel && penable && !pwrite;
        setup   = psel && !penable;
        st_nxt.irq  = '0;
        st_nxt.dma  = 2'b00;
        st_nxt.wake = 1'b0;

        // Timers
        ext_rise        = external_timer_clock_pin & ~st_r.ext_prev;
        st_nxt.ext_prev = external_timer_clock_pin;
        pair            = st_r.lo_ctrl[`ICTB_TPAIR];
        // Gate input shares the clock pin, which is free while pclk is the source
        lo_src = st_r.lo_ctrl[`ICTB_TCLK_SRC] ? ext_rise[0] :
                 (st_r.lo_ctrl[`ICTB_GATE_EN] ? external_timer_clock_pin[0] : 1'b1);
        hi_src = st_r.hi_ctrl[`ICTB_TCLK_SRC] ? ext_rise[1] :
                 (st_r.hi_ctrl[`ICTB_GATE_EN] ? external_timer_clock_pin[1] : 1'b1);
        lo_run = st_r.lo_ctrl[`ICTB_TON] && !sleep_mode &&
                 !(idle_mode && st_r.lo_ctrl[`ICTB_TSTOP_IDLE]) &&
                 !(pair && idle_mode && st_r.hi_ctrl[`ICTB_TSTOP_IDLE]);
        hi_run = st_r.hi_ctrl[`ICTB_TON] && !sleep_mode &&
                 !(idle_mode && st_r.hi_ctrl[`ICTB_TSTOP_IDLE]);
        ps_res       = ictb_prescale(st_r.lo_ctrl[`ICTB_TPS_HI:`ICTB_TPS_LO],
                                     st_r.lo_ps, lo_src && lo_run);
        lo_tick      = ps_res[8];
        st_nxt.lo_ps = ps_res[7:0];
        ps_res       = ictb_prescale(st_r.hi_ctrl[`ICTB_TPS_HI:`ICTB_TPS_LO],
                                     st_r.hi_ps, hi_src && hi_run && !pair);
        hi_tick      = ps_res[8];
        st_nxt.hi_ps = ps_res[7:0];
        // Upper half follows the lower carry only; its own fields are bypassed except idle-stop, which also halts the lower half
        hi_inc = pair ? (lo_tick && st_r.lo_cnt == 16'hffff) : hi_tick;
        st_nxt.lo_cnt = 16'(st_r.lo_cnt + {15'h0000, lo_tick});
        st_nxt.hi_cnt = 16'(st_r.hi_cnt + {15'h0000, hi_inc});

        if (wr_acc) begin
            case (paddr)
                `ICTB_ADDR_LO_CTRL:  st_nxt.lo_ctrl = pwdata[15:0] & `ICTB_LO_CTRL_WMASK;
                `ICTB_ADDR_HI_CTRL:  st_nxt.hi_ctrl = pwdata[15:0] & `ICTB_HI_CTRL_WMASK;
                `ICTB_ADDR_LO_COUNT: st_nxt.lo_cnt  = pwdata[15:0];
                `ICTB_ADDR_HI_COUNT: st_nxt.hi_cnt  = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // Capture channels
        for (int c = 0; c < NUM_CH; c++) begin
            rise = capture_input_pin[c] && !st_r.pin_prev[c];
            fall = !capture_input_pin[c] && st_r.pin_prev[c];
            st_nxt.pin_prev[c] = capture_input_pin[c];
            elast = (st_r.cc[c][2:0] == `ICTB_MODE_RISE4) ? `ICTB_EDGE4_LAST
                                                          : `ICTB_EDGE16_LAST;
            case (st_r.cc[c][2:0])
                `ICTB_MODE_EDGE: ev = rise || fall;
                `ICTB_MODE_FALL: ev = fall;
                `ICTB_MODE_RISE: ev = rise;
                `ICTB_MODE_RISE4,
                `ICTB_MODE_RISE16: begin
                    ev = rise && st_r.edge_cnt[c] == elast;
                    if (rise) begin
                        st_nxt.edge_cnt[c] = ev ? 4'h0 : 4'(st_r.edge_cnt[c] + 4'h1);
                    end
                end
                default: ev = 1'b0;
            endcase
            if ((rise || fall) && st_r.cc[c][2:0] != `ICTB_MODE_OFF &&
                (sleep_mode || idle_mode)) begin
                st_nxt.wake = 1'b1;
            end
            tval = st_r.cc[c][`ICTB_CC_TSEL] ? st_r.lo_cnt : st_r.hi_cnt;
            pop  = rd_acc && paddr == ictb_ch_addr(c, `ICTB_CH_BUF_OFF) &&
                   st_r.fill[c] != '0;
            full = st_r.fill[c] == (PW+1)'(DEPTH) && !pop;
            push = ev && !full;
            if (ev && full) begin
                st_nxt.cc[c][`ICTB_CC_OVF] = 1'b1;
            end
            if (push) begin
                st_nxt.fifo[c][st_r.wp[c]] = tval;
                st_nxt.wp[c] = PW'(st_r.wp[c] + 1'b1);
                if (st_r.int_cnt[c] == st_r.cc[c][`ICTB_CC_CPI_HI:`ICTB_CC_CPI_LO]) begin
                    st_nxt.irq[c]     = 1'b1;
                    st_nxt.int_cnt[c] = 2'b00;
                end else begin
                    st_nxt.int_cnt[c] = 2'(st_r.int_cnt[c] + 2'b01);
                end
                // DMA expects one word per request, so software keeps the field at 00
                if (c < 2) begin
                    st_nxt.dma[1'(c)] = 1'b1;
                end
            end
            if (pop) begin
                st_nxt.rp[c] = PW'(st_r.rp[c] + 1'b1);
            end
            st_nxt.fill[c] = (PW+1)'(st_r.fill[c] + {{PW{1'b0}}, push} -
                                     {{PW{1'b0}}, pop});
            if (wr_acc && paddr == ictb_ch_addr(c, `ICTB_CH_CTRL_OFF)) begin
                // Status bits survive the write so a same-cycle overflow is kept
                st_nxt.cc[c] = (pwdata[7:0] & `ICTB_CC_WMASK) |
                               (st_nxt.cc[c] & ~`ICTB_CC_WMASK);
                st_nxt.edge_cnt[c] = 4'h0;
                st_nxt.int_cnt[c]  = 2'b00;
            end
            // Turning a channel off flushes it and clears its overflow
            if (st_nxt.cc[c][2:0] == `ICTB_MODE_OFF) begin
                st_nxt.cc[c][`ICTB_CC_OVF] = 1'b0;
                st_nxt.fill[c]     = '0;
                st_nxt.wp[c]       = '0;
                st_nxt.rp[c]       = '0;
                st_nxt.edge_cnt[c] = 4'h0;
                st_nxt.int_cnt[c]  = 2'b00;
            end
        end

        // Read data prepared in the setup phase, presented in the access phase
        if (setup) begin
            st_nxt.rdata  = 32'h0000_0000;
            st_nxt.slverr = 1'b0;
            case (paddr)
                `ICTB_ADDR_LO_CTRL:  st_nxt.rdata = {16'h0000, st_r.lo_ctrl};
                `ICTB_ADDR_HI_CTRL:  st_nxt.rdata = {16'h0000, st_r.hi_ctrl};
                `ICTB_ADDR_LO_COUNT: st_nxt.rdata = {16'h0000, st_r.lo_cnt};
                `ICTB_ADDR_HI_COUNT: st_nxt.rdata = {16'h0000, st_r.hi_cnt};
                default:             st_nxt.slverr = 1'b1;
            endcase
            for (int c = 0; c < NUM_CH; c++) begin
                if (paddr == ictb_ch_addr(c, `ICTB_CH_CTRL_OFF)) begin
                    st_nxt.slverr = 1'b0;
                    st_nxt.rdata  = {24'h000000, st_r.cc[c][7:4],
                                     st_r.fill[c] != '0, st_r.cc[c][2:0]};
                end
                if (paddr == ictb_ch_addr(c, `ICTB_CH_BUF_OFF)) begin
                    st_nxt.slverr = 1'b0;
                    st_nxt.rdata  = (st_r.fill[c] != '0) ?
                                    {16'h0000, st_r.fifo[c][st_r.rp[c]]} : 32'h0000_0000;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r         <= '0;
            st_r.lo_ctrl <= `ICTB_TCTRL_RESET;
            st_r.hi_ctrl <= `ICTB_TCTRL_RESET;
            for (int c = 0; c < NUM_CH; c++) begin
                st_r.cc[c] <= `ICTB_CC_RESET;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata      = st_r.rdata;
    assign pready      = 1'b1;
    assign pslverr     = st_r.slverr;
    assign capture_irq = st_r.irq;
    assign dma_req     = st_r.dma;
    assign wake_req    = st_r.wake;

endmodule

`default_nettype wire

// ### ictb_params.svh
`ifndef ICTB_PARAMS_SVH
`define ICTB_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ICTB_ADDR_LO_CTRL   12'h000
`define ICTB_ADDR_HI_CTRL   12'h004
`define ICTB_ADDR_LO_COUNT  12'h008
`define ICTB_ADDR_HI_COUNT  12'h00c
`define ICTB_CH_BASE        12'h040
`define ICTB_CH_STRIDE      12'h008
`define ICTB_CH_CTRL_OFF    12'h000
`define ICTB_CH_BUF_OFF     12'h004

// ----------------------------------------------------------------
// Timer control fields and reset values
// ----------------------------------------------------------------
`define ICTB_TON            15
`define ICTB_TSTOP_IDLE     13
`define ICTB_GATE_EN        6
`define ICTB_TPS_HI         5
`define ICTB_TPS_LO         4
`define ICTB_TPAIR          3
`define ICTB_TCLK_SRC       1
`define ICTB_LO_CTRL_WMASK  16'ha07a
`define ICTB_HI_CTRL_WMASK  16'ha072
`define ICTB_TCTRL_RESET    16'h0000

// ----------------------------------------------------------------
// Capture channel control fields
// ----------------------------------------------------------------
`define ICTB_CC_TSEL        7
`define ICTB_CC_CPI_HI      6
`define ICTB_CC_CPI_LO      5
`define ICTB_CC_OVF         4
`define ICTB_CC_BNE         3
`define ICTB_CC_WMASK       8'he7
`define ICTB_CC_RESET       8'h00

`define ICTB_MODE_OFF       3'h0
`define ICTB_MODE_EDGE      3'h1
`define ICTB_MODE_FALL      3'h2
`define ICTB_MODE_RISE      3'h3
`define ICTB_MODE_RISE4     3'h4
`define ICTB_MODE_RISE16    3'h5

// ----------------------------------------------------------------
// Timer prescale terminal counts and capture prescale
// ----------------------------------------------------------------
`define ICTB_PS1_LAST       8'd0
`define ICTB_PS8_LAST       8'd7
`define ICTB_PS64_LAST      8'd63
`define ICTB_PS256_LAST     8'd255
`define ICTB_EDGE4_LAST     4'd3
`define ICTB_EDGE16_LAST    4'd15
`define ICTB_FIFO_DEPTH     4
`define ICTB_NUM_CH         8

`endif

// ### ictb_pkg.sv
`default_nettype none
package ictb_pkg;
    typedef logic [15:0] ictb_word_t;
    typedef logic [2:0]  ictb_mode_t;
    typedef logic [7:0]  ictb_ps_t;
endpackage
`default_nettype wire

// ### ictb_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ictb_properties #(
    parameter int NUM_CH = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              idle_mode,
    input wire logic              sleep_mode,
    input wire logic [1:0]        external_timer_clock_pin,
    input wire logic [NUM_CH-1:0] capture_input_pin,
    input wire logic [NUM_CH-1:0] capture_irq,
    input wire logic [1:0]        dma_req,
    input wire logic              wake_req
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    unmapped_err_a: assert property (psel && !penable && paddr inside {[12'h010:12'h03f]}
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && !penable && paddr < 12'h010 &&
        paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable))
        else $error("read data moved outside setup");
    dma0_edge_a: assert property (dma_req[0] |->
        $past(capture_input_pin[0]) != $past(capture_input_pin[0], 2))
        else $error("dma request without pin edge");
    dma1_edge_a: assert property (dma_req[1] |->
        $past(capture_input_pin[1]) != $past(capture_input_pin[1], 2))
        else $error("second dma request without pin edge");
    irq_dma_a: assert property (capture_irq[0] |-> dma_req[0])
        else $error("interrupt without stored capture");
    irq1_edge_a: assert property (capture_irq[1] |->
        $past(capture_input_pin[1]) != $past(capture_input_pin[1], 2))
        else $error("channel interrupt without its own edge");
    wake_mode_a: assert property (wake_req |-> $past(sleep_mode) || $past(idle_mode))
        else $error("wake outside low power");
    wake_edge_a: assert property (wake_req |->
        $past(capture_input_pin) != $past(capture_input_pin, 2))
        else $error("wake without pin edge");

    cover property (capture_irq[0]);
    cover property (wake_req);
    cover property (pslverr);
    cover property (dma_req[1]);
endmodule
`default_nettype wire

// ### ictb_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
module ictb_pulse_src (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [7:0] gap,
    output logic            pin,
    output logic [7:0]      toggles
);
    logic [7:0] cnt_r;
    // Level holds while stopped, so stopping makes no stray edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r   <= 8'h00;
            pin     <= 1'b0;
            toggles <= 8'h00;
        end else if (!run) begin
            cnt_r   <= 8'h00;
            toggles <= 8'h00;
        end else if (cnt_r == gap - 8'h01) begin
            cnt_r   <= 8'h00;
            pin     <= ~pin;
            toggles <= toggles + 8'h01;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### ictb_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ictb_params.svh"
module ictb_tb
    import ictb_pkg::*;
;
    localparam logic [11:0] CH0_CTRL = `ICTB_CH_BASE + `ICTB_CH_CTRL_OFF;
    localparam logic [11:0] CH0_BUF  = `ICTB_CH_BASE + `ICTB_CH_BUF_OFF;
    localparam logic [11:0] CH1_CTRL = `ICTB_CH_BASE + `ICTB_CH_STRIDE;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        idle_mode, sleep_mode, run, src_pin, cap1, tog_en, wake_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  ext_pin, irq, dma;
    logic [7:0]  gap, toggles;
    int          err_total, total_checks, irq_cnt, dma_cnt, wake_cnt;

    ictb_top #(.NUM_CH(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .external_timer_clock_pin(ext_pin), .capture_input_pin({cap1, src_pin}),
        .capture_irq(irq), .dma_req(dma), .wake_req(wake_req));
    ictb_pulse_src u_src (.pclk(pclk), .presetn(presetn), .run(run), .gap(gap),
        .pin(src_pin), .toggles(toggles));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Ext pins toggle each cycle: one rising edge every two cycles
    always @(posedge pclk) begin
        ext_pin <= tog_en ? ~ext_pin : 2'b00;
        cap1    <= 1'($urandom);
    end
    always @(negedge pclk) begin
        if (irq[0] === 1'b1) irq_cnt++;
        if (dma[0] === 1'b1) dma_cnt++;
        if (wake_req === 1'b1) wake_cnt++;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Counts over 512 cycles, derived from source, gate, idle and prescale
    function automatic logic [31:0] exp_delta(input logic [15:0] c, input logic t, input logic i);
        logic [31:0] n;
        n = (c[`ICTB_TCLK_SRC] || c[`ICTB_GATE_EN]) ? (t ? 32'd256 : 32'd0) : 32'd512;
        if (i && c[`ICTB_TSTOP_IDLE]) n = 32'd0;
        case (c[`ICTB_TPS_HI:`ICTB_TPS_LO])
            2'b01: n = n >> 3;
            2'b10: n = n >> 6;
            2'b11: n = n >> 8;
            default: ;
        endcase
        return n;
    endfunction
    function automatic logic [31:0] exp_gap(input int m, input logic [7:0] g);
        case (m)
            1: return 32'(g);
            4: return 32'(g) << 3;
            5: return 32'(g) << 5;
            default: return 32'(g) << 1;
        endcase
    endfunction

    logic [15:0] t_ctrl [10] = '{16'h8000, 16'h8010, 16'h8020, 16'h8030, 16'h8002,
                                 16'h8042, 16'h8040, 16'h8040, 16'ha000, 16'h8000};
    logic [9:0]  t_tog = 10'b0001110000;
    logic [9:0]  t_idl = 10'b1100000000;

    initial begin
        logic [31:0] q, p;
        logic        e;
        logic [15:0] u;
        {psel, penable, pwrite, paddr, pwdata} <= '0;
        {idle_mode, sleep_mode, run, tog_en, presetn} <= '0;
        {err_total, total_checks, irq_cnt, dma_cnt, wake_cnt} = '0;
        gap <= 8'd8;
        void'($urandom(32'ha116ced4));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (t_ctrl[i]) begin
            rd(12'(i * 4 % 64), q);
            check(q, 32'h0);
        end
        apb(1'b0, 12'h020, 32'h0, q, e);
        check({q[30:0], e}, 32'h1);
        wr(`ICTB_ADDR_HI_CTRL, 32'hffffffff);
        rd(`ICTB_ADDR_HI_CTRL, q);
        check(q, 32'(`ICTB_HI_CTRL_WMASK));
        wr(CH0_CTRL, 32'hff);
        rd(CH0_CTRL, q);
        check(q, 32'(`ICTB_CC_WMASK));
        foreach (t_ctrl[i]) begin
            tog_en    <= t_tog[i];
            idle_mode <= t_idl[i];
            wr(`ICTB_ADDR_LO_CTRL, 32'(t_ctrl[i]));
            rd(`ICTB_ADDR_LO_COUNT, p);
            repeat (509) @(posedge pclk);
            rd(`ICTB_ADDR_LO_COUNT, q);
            check(32'(16'(q - p)), exp_delta(t_ctrl[i], t_tog[i], t_idl[i]));
        end
        u = 16'($urandom);
        wr(`ICTB_ADDR_LO_CTRL, 32'h0);
        wr(`ICTB_ADDR_HI_COUNT, 32'(u));
        wr(`ICTB_ADDR_LO_COUNT, 32'hfff0);
        wr(`ICTB_ADDR_HI_CTRL, 32'h8072);
        wr(`ICTB_ADDR_LO_CTRL, 32'h8008);
        repeat (40) @(posedge pclk);
        rd(`ICTB_ADDR_HI_COUNT, q);
        check(q, 32'(16'(u + 16'h1)));
        idle_mode <= 1'b0;
        wr(`ICTB_ADDR_LO_CTRL, 32'h8000);
        wr(CH1_CTRL, 32'h01);
        for (int m = 1; m <= 5; m++) begin
            gap <= 8'(4 + $urandom_range(3));
            wr(CH0_CTRL, 32'h0);
            wr(CH0_CTRL, 32'he0 | 32'(m));
            p = 32'(irq_cnt);
            run <= 1'b1;
            for (int k = 0; k < 20000 && irq_cnt == int'(p); k++) @(posedge pclk);
            repeat (40 * gap) @(posedge pclk);
            run <= 1'b0;
            rd(CH0_CTRL, q);
            check(q, 32'hf8 | 32'(m));
            rd(CH0_BUF, p);
            for (int i = 0; i < 3; i++) begin
                rd(CH0_BUF, q);
                check(32'(ictb_word_t'(q[15:0] - p[15:0])), exp_gap(m, gap));
                p = q;
            end
            rd(CH0_CTRL, q);
            check(q, 32'hf0 | 32'(m));
            rd(CH0_BUF, q);
            check(q, 32'h0);
        end
        wr(CH1_CTRL, 32'h0);
        gap <= 8'd8;
        for (int k = 0; k < 4; k++) begin
            wr(CH0_CTRL, 32'h0);
            sleep_mode <= (k == 1);
            idle_mode  <= (k == 2);
            wr(CH0_CTRL, 32'h83 | (32'(k) << 5));
            {irq_cnt, dma_cnt, wake_cnt} = '0;
            run <= 1'b1;
            for (int i = 0; i < 2000 && toggles !== 8'd8; i++) @(posedge pclk);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            check(32'(irq_cnt), 32'(4 / (k + 1)));
            check(32'(dma_cnt), 32'd4);
            check(32'(wake_cnt), (k == 1 || k == 2) ? 32'd8 : 32'd0);
        end
        close_out();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        err_total++;
        close_out();
    end
endmodule
bind ictb_top ictb_properties #(.NUM_CH(NUM_CH)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .external_timer_clock_pin(external_timer_clock_pin),
    .capture_input_pin(capture_input_pin), .capture_irq(capture_irq), .dma_req(dma_req),
    .wake_req(wake_req));
`default_nettype wire
